// ==== core/mei_cfg.svh ====
`ifndef MEI_CFG_SVH
`define MEI_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MEI_OFS_STATUS     8'h00
`define MEI_OFS_ENABLE     8'h04
`define MEI_OFS_THRESH     8'h08
`define MEI_OFS_MAC_CONTROL_REGISTER    8'h0C
`define MEI_OFS_DMA_CONTROL_REGISTER    8'h10
`define MEI_OFS_PROGRESS   8'h14
`define MEI_OFS_TXSTAT     8'h18
`define MEI_OFS_REQUEST    8'h1C
`define MEI_OFS_STATBASE   8'h40
// ----------------------------------------
// Indication bit positions
// ----------------------------------------
`define MEI_BIT_SUMMARY    0
`define MEI_BIT_HOSTFAULT  1
`define MEI_BIT_TXDONE     2
`define MEI_BIT_RXDONE     3
`define MEI_BIT_EARLY      4
`define MEI_BIT_HOSTREQ    5
`define MEI_BIT_LINK       6
`define MEI_BIT_TXDMA      7
`define MEI_BIT_RXDMA      8
`define MEI_BIT_CTRLFRM    9
`define MEI_BIT_WARN       10
`define MEI_W1C_MASK       11'h3F1
// ----------------------------------------
// Control fields and resets
// ----------------------------------------
`define MEI_BIT_COUNTEN    0
`define MEI_BIT_EARLYDMA   0
`define MEI_RST_THRESH     16'h0008
`define MEI_MIN_EARLY      16'h0008
`endif

// ==== core/mei_pkg.sv ====
package mei_pkg;
   typedef logic [31:0] mei_word_t;
   typedef enum logic [3:0] {
      MEI_TX_OK, MEI_TX_BCAST, MEI_TX_MCAST, MEI_TX_OCTETS,
      MEI_TX_DEFER, MEI_TX_XSDEFER, MEI_TX_SINGLE, MEI_TX_MULTI,
      MEI_TX_LATE, MEI_TX_XSCOLL, MEI_TX_CARRIER, MEI_RX_OK,
      MEI_RX_BCAST, MEI_RX_MCAST, MEI_RX_OCTETS, MEI_RX_OVERRUN
   } mei_stat_e;
endpackage : mei_pkg

// ==== core/mei_stat_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mei_stat_if;
   logic        countEn;
   logic        wrEn;
   logic        rdEn;
   logic [31:0] wrData;
   logic [31:0] value;
   logic        warn;
   logic [15:0] inc;
   modport owner (output countEn, wrEn, rdEn, wrData, inc, input value, warn);
   modport counter (input countEn, wrEn, rdEn, wrData, inc, output value, warn);
endinterface : mei_stat_if
`default_nettype wire

// ==== core/mei_stat_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module mei_stat_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic   ref_clk,
   input  wire logic   resetn,
   mei_stat_if.counter bus
);
   import mei_pkg::*;
   initial begin
      if (WIDTH < 2 || WIDTH > 32) $error("mei_stat_counter: WIDTH out of range");
   end
   localparam logic [WIDTH-1:0] WARN_LVL = WIDTH'((64'(3) << WIDTH) / 64'(4));
   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;
   logic [WIDTH-1:0] addend;
   // Read clears; write adds; counting only while enabled [RL16] [RL17]
   assign addend    = bus.wrEn ? bus.wrData[WIDTH-1:0] : (bus.countEn ? WIDTH'(bus.inc) : '0);
   // An event in the read cycle lands in the cleared counter, so no count is lost
   assign count_nxt = (bus.rdEn ? '0 : count_r) + addend;
   assign bus.value = 32'(count_r);
   assign bus.warn  = count_r >= WARN_LVL; // [RL18]
   always_ff @(posedge ref_clk) begin
      if (!resetn) count_r <= '0;
      else count_r <= count_nxt;
   end
   property p_read_clears;
      @(posedge ref_clk) disable iff (!resetn)
         bus.rdEn && !bus.wrEn |=> count_r == ($past(bus.countEn) ? WIDTH'($past(bus.inc)) : '0);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // [RL17]
   property p_hold_disabled;
      @(posedge ref_clk) disable iff (!resetn)
         (!bus.countEn && !bus.wrEn && !bus.rdEn) |=> $stable(count_r);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) else $error("counted while off"); // [RL16]
endmodule : mei_stat_counter
`default_nettype wire

// ==== core/mei_event_top.sv ====
// Contract
// RL1 - Early indication once bytes exceed threshold
// RL2 - Early indication once per head frame
// RL3 - Host programs threshold at least 0x08
// RL4 - No early indication before 8 bytes
// RL5 - Early DMA start once threshold reached
// RL6 - Short frame gives receive-done only
// RL7 - Receive-done clears early indication
// RL8 - Host disables done only with early
// RL9 - Progress register reports bytes moved
// RL10 - Ten indications gated by enable mask
// RL11 - Summary bit set on any interrupt
// RL12 - Summary bit cleared by writing one
// RL13 - Six indications cleared by writing one
// RL14 - Receive-done clears itself automatically
// RL15 - Transmit status write clears transmit-done
// RL16 - Sixteen counters count only when enabled
// RL17 - Read clears, write adds to counter
// RL18 - Warning at 75 percent, read acknowledges
// RL19 - Transmit good, bcast, mcast, octet counts
// RL20 - Collision and excess-collision counts
// RL21 - Deferral and carrier-loss counts
// RL22 - Receive good counts and overrun drops
// RL23 - Interrupt follows enabled set indications
`include "mei_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mei_event_top (
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic [7:0]          regAddr,
   input  wire logic [31:0]         regWrData,
   input  wire logic                regWrEn,
   input  wire logic                regRdEn,
   output logic [31:0]              regRdData,
   output logic                     interruptOut,
   output logic                     earlyDmaStart,
   input  wire logic                rxByte,
   input  wire logic                rxFrameEnd,
   input  wire logic                rxFrameHead,
   input  wire logic                rxDmaByte,
   input  wire logic                rxDmaNewDesc,
   input  wire logic                hostFaultEvt,
   input  wire logic                hostFaultReset,
   input  wire logic                txDoneEvt,
   input  wire logic                linkEvt,
   input  wire logic                txDmaEvt,
   input  wire logic                rxDmaEvt,
   input  wire logic                ctrlFrameEvt,
   input  wire mei_pkg::mei_word_t  statEvents
);
   import mei_pkg::*;
   localparam int NCNT = 16;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire wrStatus   = regWrEn && hit(regAddr, `MEI_OFS_STATUS);
   wire wrEnable   = regWrEn && hit(regAddr, `MEI_OFS_ENABLE);
   wire wrThresh   = regWrEn && hit(regAddr, `MEI_OFS_THRESH);
   wire wrMacCtrl  = regWrEn && hit(regAddr, `MEI_OFS_MAC_CONTROL_REGISTER);
   wire wrDmaCtrl  = regWrEn && hit(regAddr, `MEI_OFS_DMA_CONTROL_REGISTER);
   wire wrTxStat   = regWrEn && hit(regAddr, `MEI_OFS_TXSTAT);
   wire wrRequest  = regWrEn && hit(regAddr, `MEI_OFS_REQUEST) && regWrData[0];
   wire statSpace  = regAddr[7:6] == 2'(`MEI_OFS_STATBASE >> 6);
   wire [3:0] statIdx = regAddr[5:2];

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [10:0] enable_r;
   logic [15:0] thresh_r;
   logic        countEn_r;
   logic        earlyDmaEn_r;
   // Interrupt sees a mask write in the same cycle as the status it gates
   wire  [10:0] enableNxt = wrEnable ? regWrData[10:0] : enable_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         enable_r     <= '0;
         thresh_r     <= `MEI_RST_THRESH;
         countEn_r    <= 1'b0;
         earlyDmaEn_r <= 1'b0;
      end else begin
         if (wrEnable) enable_r <= regWrData[10:0];
         if (wrThresh) thresh_r <= regWrData[15:0];
         if (wrMacCtrl) countEn_r <= regWrData[`MEI_BIT_COUNTEN];
         if (wrDmaCtrl) earlyDmaEn_r <= regWrData[`MEI_BIT_EARLYDMA];
      end
   end

   // ----------------------------------------
   // Receive byte tracking
   // ----------------------------------------
   logic [15:0] rxCount_r;
   logic        earlyDone_r;
   logic [15:0] progress_r;
   wire  [15:0] rxCountNow = rxCount_r + 16'(rxByte);
   // Never below 8 bytes, since address filtering needs them [RL4]
   wire         pastMin    = rxCountNow >= `MEI_MIN_EARLY;
   wire         overThresh = rxCountNow > thresh_r && pastMin; // [RL1]
   // A frame ending in the same cycle gets receive-done instead [RL6]
   wire earlyFire = overThresh && !earlyDone_r && rxFrameHead && !rxFrameEnd // [RL2]
                    && enable_r[`MEI_BIT_EARLY];
   wire dmaEligible = earlyDmaEn_r && rxCountNow >= thresh_r && pastMin; // [RL5]

   always_ff @(posedge ref_clk) begin
      if (!resetn || rxFrameEnd) begin
         rxCount_r   <= '0;
         earlyDone_r <= 1'b0;
      end else begin
         rxCount_r   <= rxCountNow;
         if (earlyFire) earlyDone_r <= 1'b1; // [RL2]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn || rxDmaNewDesc) progress_r <= '0;
      else if (rxDmaByte) progress_r <= progress_r + 16'h0001; // [RL9]
   end

   // ----------------------------------------
   // Statistics counters
   // ----------------------------------------
   logic [NCNT-1:0] warnVec;
   logic [31:0]     cntVal [NCNT];
   logic [15:0]     incs   [NCNT];
   // Octet counters take a byte count per frame; others count single events
   always_comb begin
      for (int k = 0; k < NCNT; k++) incs[k] = 16'(statEvents[k]); // [RL19] [RL20] [RL21] [RL22]
      incs[MEI_TX_OCTETS] = statEvents[MEI_TX_OCTETS] ? 16'h05EE : 16'h0000;
      incs[MEI_RX_OCTETS] = statEvents[MEI_RX_OCTETS] ? 16'h05EE : 16'h0000;
   end

   generate
      for (genvar g = 0; g < NCNT; g++) begin : g_cnt
         localparam int W = (g == MEI_TX_OCTETS || g == MEI_RX_OCTETS) ? 32 : 16;
         mei_stat_if sif ();
         assign sif.countEn = countEn_r; // [RL16]
         assign sif.wrEn    = regWrEn && statSpace && statIdx == 4'(g); // [RL17]
         assign sif.rdEn    = regRdEn && statSpace && statIdx == 4'(g);
         assign sif.wrData  = regWrData;
         assign sif.inc     = incs[g];
         assign cntVal[g]   = sif.value;
         assign warnVec[g]  = sif.warn;
         mei_stat_counter #(.WIDTH(W)) u_cnt (
            .ref_clk (ref_clk),
            .resetn  (resetn),
            .bus     (sif)
         );
      end
   endgenerate

   // ----------------------------------------
   // Indication status
   // ----------------------------------------
   logic [10:0] status_r;
   logic [10:0] setVec;
   logic [10:0] clrVec;
   logic [10:0] status_nxt;
   // Every frame end reports receive-done; only early needs the head frame
   wire  rxDoneSet  = rxFrameEnd; // [RL6]
   wire  anyIrq     = |(status_r[10:1] & enable_r[10:1]);
   assign setVec = {|warnVec, ctrlFrameEvt, rxDmaEvt, txDmaEvt, linkEvt, wrRequest,
                    earlyFire, rxDoneSet, txDoneEvt, hostFaultEvt, anyIrq}; // [RL11]
   // Write-one clears on the summary and the six event bits [RL12] [RL13]
   wire  [10:0] w1c = wrStatus ? (regWrData[10:0] & `MEI_W1C_MASK) : 11'h000;
   always_comb begin
      clrVec = w1c;
      clrVec[`MEI_BIT_TXDONE]    = wrTxStat; // [RL15]
      clrVec[`MEI_BIT_HOSTFAULT] = hostFaultReset;
      // Counter warning drops once no counter sits at or above its warning level
      clrVec[`MEI_BIT_WARN]      = !(|warnVec); // [RL18]
      // Receive-done self-clears when the host reads status [RL14]
      clrVec[`MEI_BIT_RXDONE]    = regRdEn && hit(regAddr, `MEI_OFS_STATUS);
      // Set wins over clear for every bit
      status_nxt = (status_r & ~clrVec) | setVec;
      if (rxDoneSet) status_nxt[`MEI_BIT_EARLY] = 1'b0; // [RL7]
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) status_r <= '0;
      else status_r <= status_nxt;
   end

   // ----------------------------------------
   // Read mux and outputs
   // ----------------------------------------
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      if (statSpace) rdMux = cntVal[statIdx];
      else case (regAddr)
         `MEI_OFS_STATUS:   rdMux = 32'(status_r);
         `MEI_OFS_ENABLE:   rdMux = 32'(enable_r);
         `MEI_OFS_THRESH:   rdMux = 32'(thresh_r);
         `MEI_OFS_MAC_CONTROL_REGISTER:  rdMux = 32'(countEn_r);
         `MEI_OFS_DMA_CONTROL_REGISTER:  rdMux = 32'(earlyDmaEn_r);
         `MEI_OFS_PROGRESS: rdMux = 32'(progress_r);
         default:           rdMux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         regRdData     <= '0;
         interruptOut  <= 1'b0;
         earlyDmaStart <= 1'b0;
      end else begin
         regRdData     <= regRdEn ? rdMux : 32'h0000_0000;
         interruptOut  <= |(status_nxt[10:1] & enableNxt[10:1]); // [RL10] [RL23]
         earlyDmaStart <= dmaEligible;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_mutex;
      @(posedge ref_clk) disable iff (!resetn)
         !(status_r[`MEI_BIT_EARLY] && status_r[`MEI_BIT_RXDONE] && $past(rxDoneSet));
   endproperty
   a_mutex: assert property (p_mutex) else $error("early and done both set"); // [RL7]
   property p_min8;
      @(posedge ref_clk) disable iff (!resetn) earlyFire |-> rxCountNow >= 16'h0008;
   endproperty
   a_min8: assert property (p_min8) else $error("early before 8 bytes"); // [RL4]
   property p_once;
      @(posedge ref_clk) disable iff (!resetn) earlyFire |=> !earlyFire || $past(rxFrameEnd);
   endproperty
   a_once: assert property (p_once) else $error("early twice"); // [RL2]
   property p_irq;
      @(posedge ref_clk) disable iff (!resetn)
         |(status_r[10:1] & enable_r[10:1]) |-> interruptOut || $past(!resetn);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing"); // [RL23]
   property p_summary;
      @(posedge ref_clk) disable iff (!resetn) interruptOut |=> status_r[0];
   endproperty
   a_summary: assert property (p_summary) else $error("summary not set"); // [RL11]
   property p_txclr;
      @(posedge ref_clk) disable iff (!resetn) wrTxStat && !txDoneEvt |=> !status_r[2];
   endproperty
   a_txclr: assert property (p_txclr) else $error("tx done not cleared"); // [RL15]
   property p_rdclr;
      @(posedge ref_clk) disable iff (!resetn)
         regRdEn && hit(regAddr, `MEI_OFS_STATUS) && !rxDoneSet |=> !status_r[3];
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("rx done stayed"); // [RL14]
   property p_sumhold;
      @(posedge ref_clk) disable iff (!resetn) status_r[0] && !wrStatus |=> status_r[0];
   endproperty
   a_sumhold: assert property (p_sumhold) else $error("summary dropped"); // [RL12]

   // ----------------------------------------
   // Checks on receive path and acknowledges
   // ----------------------------------------
   property p_early_set;
      @(posedge ref_clk) disable iff (!resetn)
         earlyFire |=> status_r[4];
   endproperty
   a_early_set: assert property (p_early_set) else $error("early not set"); // [RL1]

   property p_early_head;
      @(posedge ref_clk) disable iff (!resetn)
         !rxFrameHead && !status_r[4] |=> !status_r[4];
   endproperty
   a_early_head: assert property (p_early_head) else $error("early off head"); // [RL2]

   property p_dma_gate;
      @(posedge ref_clk) disable iff (!resetn)
         earlyDmaStart |-> $past(earlyDmaEn_r);
   endproperty
   a_dma_gate: assert property (p_dma_gate) else $error("dma start not enabled"); // [RL5]

   property p_dma_min;
      @(posedge ref_clk) disable iff (!resetn)
         earlyDmaStart |-> $past(rxCountNow) >= 16'h0008;
   endproperty
   a_dma_min: assert property (p_dma_min) else $error("dma start before 8 bytes"); // [RL4]

   property p_end_early;
      @(posedge ref_clk) disable iff (!resetn)
         rxFrameEnd |=> !status_r[4];
   endproperty
   a_end_early: assert property (p_end_early) else $error("early kept at end"); // [RL7]

   property p_done_set;
      @(posedge ref_clk) disable iff (!resetn)
         rxFrameEnd |=> status_r[3];
   endproperty
   a_done_set: assert property (p_done_set) else $error("rx done not set"); // [RL6]

   property p_masked;
      @(posedge ref_clk) disable iff (!resetn)
         interruptOut |-> |(status_r[10:1] & enable_r[10:1]);
   endproperty
   a_masked: assert property (p_masked) else $error("masked interrupt"); // [RL10]

   property p_req_hold;
      @(posedge ref_clk) disable iff (!resetn)
         status_r[5] && !wrStatus |=> status_r[5];
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped"); // [RL13]

   property p_link_w1c;
      @(posedge ref_clk) disable iff (!resetn)
         wrStatus && regWrData[6] && !linkEvt |=> !status_r[6];
   endproperty
   a_link_w1c: assert property (p_link_w1c) else $error("link not cleared"); // [RL13]

   property p_fault_clr;
      @(posedge ref_clk) disable iff (!resetn)
         hostFaultReset && !hostFaultEvt |=> !status_r[1];
   endproperty
   a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared"); // [RL15]

   property p_tx_hold;
      @(posedge ref_clk) disable iff (!resetn)
         status_r[2] && !wrTxStat |=> status_r[2];
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx done dropped"); // [RL15]

   property p_warn_set;
      @(posedge ref_clk) disable iff (!resetn)
         |warnVec |=> status_r[10];
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("warning not set"); // [RL18]

   property p_prog_inc;
      @(posedge ref_clk) disable iff (!resetn)
         rxDmaByte && !rxDmaNewDesc |=> progress_r == $past(progress_r) + 16'h0001;
   endproperty
   a_prog_inc: assert property (p_prog_inc) else $error("progress not counted"); // [RL9]

   property p_prog_clr;
      @(posedge ref_clk) disable iff (!resetn)
         rxDmaNewDesc |=> progress_r == 16'h0000;
   endproperty
   a_prog_clr: assert property (p_prog_clr) else $error("progress not cleared"); // [RL9]
endmodule : mei_event_top
`default_nettype wire

// ==== tb/mei_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mei_host_model (
   input  wire logic                ref_clk,
   output var  logic [7:0]          regAddr,
   output var  mei_pkg::mei_word_t  regWrData,
   output var  logic                regWrEn,
   output var  logic                regRdEn,
   input  wire mei_pkg::mei_word_t  regRdData
);
   import mei_pkg::*;
   // ----------------------------------------
   // Driver side of the register port
   // ----------------------------------------
   initial begin
      regAddr   = 8'h00;
      regWrData = 32'h0000_0000;
      regWrEn   = 1'b0;
      regRdEn   = 1'b0;
   end
   // One idle cycle after each access, so a strobe is never assigned twice in one step
   task automatic wr(input logic [7:0] a, input mei_word_t d);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge ref_clk);
      regWrEn <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   // Data is only valid in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output mei_word_t d);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
      @(posedge ref_clk);
   endtask : rd
   // Acknowledge by writing ones; receive-done is never masked while early stays enabled
   task automatic ack(input mei_word_t bits);
      wr(`MEI_OFS_STATUS, bits);
   endtask : ack
endmodule : mei_host_model
`default_nettype wire

// ==== tb/mei_event_top_test.sv ====
`include "mei_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mei_event_top_test;
   import mei_pkg::*;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   logic        ref_clk     = 1'b0;
   logic        resetn      = 1'b0;
   logic        rxFrameHead;
   logic        rxByte, rxFrameEnd, rxDmaByte, rxDmaNewDesc, hostFaultEvt, hostFaultReset;
   logic        txDoneEvt, linkEvt, txDmaEvt, rxDmaEvt, ctrlFrameEvt;
   mei_word_t   statEvents;
   wire  [7:0]  regAddr;
   wire  [31:0] regWrData;
   wire         regWrEn;
   wire         regRdEn;
   wire  [31:0] regRdData;
   wire         interruptOut;
   wire         earlyDmaStart;
   int          n_mismatch  = 0;
   int          checks      = 0;
   mei_word_t   v;
   always #50 ref_clk = ~ref_clk;
   mei_event_top mei_event_top_i (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .interruptOut(interruptOut), .earlyDmaStart(earlyDmaStart), .rxByte(rxByte),
      .rxFrameEnd(rxFrameEnd), .rxFrameHead(rxFrameHead), .rxDmaByte(rxDmaByte),
      .rxDmaNewDesc(rxDmaNewDesc), .hostFaultEvt(hostFaultEvt),
      .hostFaultReset(hostFaultReset), .txDoneEvt(txDoneEvt), .linkEvt(linkEvt),
      .txDmaEvt(txDmaEvt), .rxDmaEvt(rxDmaEvt), .ctrlFrameEvt(ctrlFrameEvt),
      .statEvents(statEvents));
   mei_host_model mei_host_model_i (.ref_clk(ref_clk), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic chk(input mei_word_t got, input mei_word_t exp, input mei_word_t msk);
      checks++;
      if ((got & msk) !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got & msk, exp);
      end
   endtask : chk
   task automatic drv(input int k, input logic b);
      case (k)
         0:       rxByte         <= b;
         1:       rxFrameEnd     <= b;
         2:       rxDmaByte      <= b;
         3:       rxDmaNewDesc   <= b;
         4:       hostFaultEvt   <= b;
         5:       hostFaultReset <= b;
         6:       txDoneEvt      <= b;
         7:       linkEvt        <= b;
         8:       txDmaEvt       <= b;
         9:       rxDmaEvt       <= b;
         default: ctrlFrameEvt   <= b;
      endcase
   endtask : drv
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         drv(k, 1'b1);
         @(posedge ref_clk);
      end
      drv(k, 1'b0);
      @(posedge ref_clk);
   endtask : pulse
   task automatic st(input mei_word_t exp, input mei_word_t msk);
      mei_host_model_i.rd(`MEI_OFS_STATUS, v);
      chk(v, exp, msk);
   endtask : st
   task automatic rdc(input logic [7:0] a, input mei_word_t exp);
      mei_host_model_i.rd(a, v);
      chk(v, exp, 32'hFFFF_FFFF);
   endtask : rdc
   // Levels are registered, so one more edge passes before sampling
   task automatic lvl(input int s, input logic e);
      @(posedge ref_clk);
      #1;
      chk({31'h0, (s != 0) ? earlyDmaStart : interruptOut}, {31'h0, e}, 32'h0000_0001);
   endtask : lvl
   task automatic sev();
      statEvents <= 32'h0000_FFFF;
      @(posedge ref_clk);
      statEvents <= 32'h0000_0000;
      @(posedge ref_clk);
   endtask : sev
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      st(32'h0000_0000, 32'hFFFF_FFFF);
      rdc(`MEI_OFS_THRESH, 32'h0000_0008);
      rdc(`MEI_OFS_ENABLE, 32'h0000_0000);
      mei_host_model_i.wr(8'h30, 32'hFFFF_FFFF);
      rdc(8'h30, 32'h0000_0000);
      lvl(0, 1'b0);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_early();
      mei_host_model_i.wr(`MEI_OFS_ENABLE, 32'h0000_0018);
      mei_host_model_i.wr(`MEI_OFS_DMA_CONTROL_REGISTER, 32'h0000_0001);
      rxFrameHead <= 1'b1;
      pulse(0, 7);
      lvl(1, 1'b0);
      pulse(0, 1);
      lvl(1, 1'b1);
      st(32'h0000_0000, 32'h0000_0010);
      pulse(0, 1);
      st(32'h0000_0010, 32'h0000_0010);
      lvl(0, 1'b1);
      mei_host_model_i.ack(32'h0000_0010);
      pulse(0, 3);
      st(32'h0000_0000, 32'h0000_0010);
      pulse(1, 1);
      st(32'h0000_0008, 32'h0000_0018);
      pulse(0, 9);
      pulse(1, 1);
      st(32'h0000_0008, 32'h0000_0018);
      st(32'h0000_0000, 32'h0000_0008);
      mei_host_model_i.ack(32'h0000_0001);
      lvl(0, 1'b0);
      mei_host_model_i.wr(`MEI_OFS_DMA_CONTROL_REGISTER, 32'h0000_0000);
      $display("t_early done");
   endtask : t_early
   task automatic t_short();
      mei_host_model_i.wr(`MEI_OFS_THRESH, 32'h0000_0040);
      rdc(`MEI_OFS_THRESH, 32'h0000_0040);
      pulse(0, 10);
      pulse(1, 1);
      st(32'h0000_0008, 32'h0000_0018);
      rxFrameHead <= 1'b0;
      pulse(0, 65);
      st(32'h0000_0000, 32'h0000_0010);
      pulse(1, 1);
      st(32'h0000_0008, 32'h0000_0008);
      mei_host_model_i.ack(32'h0000_0001);
      $display("t_short done");
   endtask : t_short
   task automatic t_ind();
      mei_host_model_i.wr(`MEI_OFS_ENABLE, 32'h0000_0000);
      mei_host_model_i.wr(`MEI_OFS_REQUEST, 32'h0000_0001);
      st(32'h0000_0020, 32'h0000_0020);
      for (int k = 7; k <= 10; k++) begin
         pulse(k, 1);
         st(32'h1 << (k - 1), 32'h1 << (k - 1));
      end
      lvl(0, 1'b0);
      mei_host_model_i.ack(32'h0000_03E0);
      st(32'h0000_0000, 32'h0000_03E1);
      pulse(4, 1);
      pulse(6, 1);
      mei_host_model_i.ack(32'h0000_0006);
      st(32'h0000_0006, 32'h0000_0006);
      pulse(5, 1);
      mei_host_model_i.wr(`MEI_OFS_TXSTAT, 32'h0000_0000);
      st(32'h0000_0000, 32'h0000_0006);
      pulse(2, 5);
      rdc(`MEI_OFS_PROGRESS, 32'h0000_0005);
      pulse(3, 1);
      rdc(`MEI_OFS_PROGRESS, 32'h0000_0000);
      $display("t_ind done");
   endtask : t_ind
   task automatic t_mask();
      mei_host_model_i.wr(`MEI_OFS_ENABLE, 32'h0000_0040);
      pulse(7, 1);
      lvl(0, 1'b1);
      st(32'h0000_0041, 32'h0000_0041);
      mei_host_model_i.ack(32'h0000_0040);
      lvl(0, 1'b0);
      st(32'h0000_0001, 32'h0000_0041);
      mei_host_model_i.ack(32'h0000_0001);
      st(32'h0000_0000, 32'h0000_0001);
      $display("t_mask done");
   endtask : t_mask
   task automatic t_stats();
      sev();
      rdc(`MEI_OFS_STATBASE, 32'h0000_0000);
      mei_host_model_i.wr(`MEI_OFS_MAC_CONTROL_REGISTER, 32'h0000_0001);
      sev();
      for (int i = 0; i < 16; i++) begin
         rdc(8'(`MEI_OFS_STATBASE + 4 * i), (i == 3 || i == 14) ? 32'h0000_05EE : 32'h0000_0001);
      end
      rdc(`MEI_OFS_STATBASE, 32'h0000_0000);
      mei_host_model_i.wr(8'h48, 32'h0000_0005);
      mei_host_model_i.wr(8'h48, 32'h0000_0003);
      rdc(8'h48, 32'h0000_0008);
      mei_host_model_i.wr(8'h44, 32'h0000_C000);
      st(32'h0000_0400, 32'h0000_0400);
      rdc(8'h44, 32'h0000_C000);
      st(32'h0000_0000, 32'h0000_0400);
      $display("t_stats done");
   endtask : t_stats
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      rxFrameHead <= 1'b0;
      statEvents  <= 32'h0000_0000;
      for (int k = 0; k <= 10; k++) drv(k, 1'b0);
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_early();
      t_short();
      t_ind();
      t_mask();
      t_stats();
      close_out();
   end
   // The sequence needs well under a thousand cycles; four thousand leaves ample margin
   initial begin
      repeat (4000) @(posedge ref_clk);
      n_mismatch++;
      $display("watchdog expired");
      close_out();
   end
endmodule : mei_event_top_test
`default_nettype wire
